// ===== rtl/stl_map.svh
// register offsets, reset values and timing constants of the supply tracking limiter
// assumes a classic wishbone slave with 32-bit data and byte addressing
`ifndef STL_MAP_SVH
`define STL_MAP_SVH
`define STL_OFF_UPPER 6'h00
`define STL_OFF_FLOOR 6'h04
`define STL_OFF_INFL 6'h08
`define STL_OFF_SLOPE 6'h0C
`define STL_OFF_BO_TH 6'h10
`define STL_OFF_SD_TH 6'h14
`define STL_OFF_CTRL 6'h18
`define STL_OFF_STAT 6'h1C
`define STL_OFF_LIMTH 6'h20
`define STL_OFF_ATTN 6'h24
`define STL_OFF_CEIL 6'h28
`define STL_RST_UPPER 32'h48000000
`define STL_RST_FLOOR 32'h20000000
`define STL_RST_INFL 32'h34CCCCCD
`define STL_RST_SLOPE 32'h08000000
`define STL_RST_BO_TH 32'h2E666666
`define STL_RST_SD_TH 32'h2B333333
`define STL_RST_CEIL 8'h12
`define STL_RST_ATK_RT 3'h0
`define STL_RST_ATK_ST 2'h1
`define STL_RST_HLD_TM 3'h6
// control register fields
`define STL_C_LIM_EN 0
`define STL_C_BO_EN 1
`define STL_C_MUTE 2
`define STL_C_INF 3
`define STL_C_HCLR 4
`define STL_C_SD_EN 5
`define STL_C_RT_LO 8
`define STL_C_RT_HI 10
`define STL_C_ST_LO 12
`define STL_C_ST_HI 13
`define STL_C_HT_LO 16
`define STL_C_HT_HI 18
`define STL_C_RL_LO 20
`define STL_C_RL_HI 22
// sample rate and hold timing
`define STL_FS_HZ 48000
`define STL_CLK_HZ 200000000
`define STL_BO_LAT_NS 10000
`define STL_SAMP_PER_MS 48
`endif

// ===== rtl/stl_pkg.sv
// types of the supply tracking limiter
// assumes stl_map.svh supplies the numeric constants
package stl_pkg;
   typedef enum logic [3:0] {
      STL_IDLE = 4'b0001,
      STL_ATTACK = 4'b0010,
      STL_HOLD = 4'b0100,
      STL_RELEASE = 4'b1000
   } stl_bo_state_t;
endpackage

// ===== rtl/stl_thresh_calc.sv
// threshold tracking arithmetic: upper minus slope times shortfall, floored
// assumes all values share volts times 2^27 scaling; combinational
module stl_thresh_calc (
   input wire logic [31:0] upper_i,
   input wire logic [31:0] floor_i,
   input wire logic [31:0] infl_i,
   input wire logic [31:0] slope_i,
   input wire logic [31:0] supply_i,
   output logic [31:0] thresh_o
);
   logic [31:0] short_v;
   logic [63:0] prod_v;
   logic [32:0] drop_v;
   logic [32:0] diff_v;
   // shortfall below the inflection point, zero above it
   assign short_v = (supply_i >= infl_i) ? 32'h00000000 : infl_i - supply_i;
   assign prod_v = 64'(short_v) * 64'(slope_i);
   assign drop_v = (prod_v[63:59] != 5'h00) ? 33'h100000000 : {1'b0, prod_v[58:27]};
   assign diff_v = {1'b0, upper_i} - drop_v;
   always_comb
   begin
      // upper above inflection, floor clamp below
      if (supply_i >= infl_i)
      begin
         thresh_o = upper_i;
      end
      else if (diff_v[32] || (diff_v[31:0] < floor_i))
      begin
         thresh_o = floor_i;
      end
      else
      begin
         thresh_o = diff_v[31:0];
      end
   end
endmodule

// ===== rtl/stl_limiter_top.sv
// supply tracking limiter threshold and brown-out prevention engine, wishbone slave
// assumes battery codes in volts times 2^27, one sample strobe per audio sample, one clock
//
// The Wishbone slave port and the register offsets were chosen for this implementation.
`include "stl_map.svh"
// Summary of operation
// - upper threshold 32-bit, volts times 2^27, resets to 9 V code.
// - floor threshold same encoding, resets to 4 V code.
// - inflection point 32-bit, resets to 0x34CCCCCD, scaling conflict noted.
// - slope 32-bit, volts per volt times 2^27, sets tracking steepness.
// - above inflection use upper; below, subtract slope times shortfall; clamp at floor.
// - default slope one volt per volt; steeper slopes honoured.
// - brown-out is priority input, attacks when battery below brown-out threshold.
// - brown-out enable resets to one, works without limiter enabled.
// - brown-out threshold 32-bit, resets to 0x2E666666.
// - attack rate code n gives 2 to the n samples per step.
// - attack step 0.5, 1, 1.5 or 2 dB, resets to 1 dB.
// - hold time 0 to 1000 ms by code, resets to 500 ms.
// - recovery after hold uses battery limiter release rate.
// - mute-on-brown-out set makes brown-out mute and shut down in the same cycle.
// - after brown-out shutdown audio stays stopped until a shutdown state passes.
// - infinite hold keeps hold until mute, shutdown or hold-release write.
// - hold-release bit self-clears and always reads zero.
// - hard shutdown enable off at reset, shuts down below shutdown level.
// - hard shutdown acts only while brown-out engine enabled.
// - shutdown threshold 32-bit, resets to 0x2B333333.
// - limiter attacks only when signal level exceeds current threshold.
// - limiter and brown-out share one attenuation ceiling.
// - first brown-out step under 10 us after crossing.
// - limiter updates frozen while brown-out active.
module stl_limiter_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [5:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic sample_stb_i,
   input wire logic [31:0] battery_i,
   input wire logic battery_vld_i,
   input wire logic [31:0] level_i,
   input wire logic shutdown_i,
   output logic [31:0] limit_thresh_o,
   output logic [7:0] attn_o,
   output logic gain_step_o,
   output logic mute_o,
   output logic shutdown_req_o,
   output logic brownout_o
);
   typedef struct packed {
      logic [31:0] upper;
      logic [31:0] floor_th;
      logic [31:0] infl;
      logic [31:0] slope;
      logic [31:0] bo_th;
      logic [31:0] sd_th;
      logic [31:0] stage;
      logic [3:0] stage_be;
      logic [5:0] stage_adr;
      logic lim_en;
      logic bo_en;
      logic mute_en;
      logic inf_hold;
      logic sd_en;
      logic [2:0] atk_rt;
      logic [1:0] atk_st;
      logic [2:0] hld_tm;
      logic [2:0] rls_rt;
      logic [7:0] ceil;
      logic [31:0] batt;
      logic [31:0] thresh;
      stl_pkg::stl_bo_state_t st;
      logic [7:0] rate_cnt;
      logic [15:0] hold_cnt;
      logic [7:0] attn;
      logic [31:0] rdata;
      logic ack;
      logic step;
      logic mute;
      logic sd_req;
      logic stopped;
   } stl_state_t;
   stl_state_t q, d;
   logic [31:0] calc_th;
   logic wr_v;
   logic below_v;

   stl_thresh_calc u_calc (
      .upper_i(q.upper),
      .floor_i(q.floor_th),
      .infl_i(q.infl),
      .slope_i(q.slope),
      .supply_i(q.batt),
      .thresh_o(calc_th)
   );

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
         begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [15:0] hold_samples(input logic [2:0] code);
      logic [15:0] ms;
      unique case (code)
         3'h0: ms = 16'h0000;
         3'h1: ms = 16'h000A;
         3'h2: ms = 16'h0019;
         3'h3: ms = 16'h0032;
         3'h4: ms = 16'h0064;
         3'h5: ms = 16'h00FA;
         3'h6: ms = 16'h01F4;
         3'h7: ms = 16'h03E8;
      endcase
      return 16'(ms * 16'(`STL_SAMP_PER_MS));
   endfunction

   function automatic logic is_thresh(input logic [5:0] a);
      return (a == `STL_OFF_UPPER) || (a == `STL_OFF_FLOOR) || (a == `STL_OFF_INFL) ||
             (a == `STL_OFF_SLOPE) || (a == `STL_OFF_BO_TH) || (a == `STL_OFF_SD_TH);
   endfunction

   assign wr_v = wb_cyc_i && wb_stb_i && wb_we_i && !q.ack;

   always_comb
   begin
      d = q;
      d.ack = wb_cyc_i && wb_stb_i && !q.ack;
      d.step = 1'b0;
      below_v = q.bo_en && (q.batt < q.bo_th);
      if (battery_vld_i)
      begin
         d.batt = battery_i;
      end
      if (wr_v && is_thresh(wb_adr_i))
      begin
         d.stage_adr = wb_adr_i;
         d.stage = merge(q.stage, wb_dat_i, wb_sel_i);
         d.stage_be = ((q.stage_adr == wb_adr_i) ? q.stage_be : 4'h0) | wb_sel_i;
         if (d.stage_be == 4'hF)
         begin
            d.stage_be = 4'h0;
            unique case (wb_adr_i)
               `STL_OFF_UPPER: d.upper = d.stage;
               `STL_OFF_FLOOR: d.floor_th = d.stage;
               `STL_OFF_INFL: d.infl = d.stage;
               `STL_OFF_SLOPE: d.slope = d.stage;
               `STL_OFF_BO_TH: d.bo_th = d.stage;
               default: d.sd_th = d.stage;
            endcase
         end
      end
      if (wr_v && (wb_adr_i == `STL_OFF_CTRL))
      begin
         if (wb_sel_i[0])
         begin
            d.lim_en = wb_dat_i[`STL_C_LIM_EN];
            d.bo_en = wb_dat_i[`STL_C_BO_EN];
            d.mute_en = wb_dat_i[`STL_C_MUTE];
            d.inf_hold = wb_dat_i[`STL_C_INF];
            d.sd_en = wb_dat_i[`STL_C_SD_EN];
         end
         if (wb_sel_i[1])
         begin
            d.atk_rt = wb_dat_i[`STL_C_RT_HI:`STL_C_RT_LO];
            d.atk_st = wb_dat_i[`STL_C_ST_HI:`STL_C_ST_LO];
         end
         if (wb_sel_i[2])
         begin
            d.hld_tm = wb_dat_i[`STL_C_HT_HI:`STL_C_HT_LO];
            d.rls_rt = wb_dat_i[`STL_C_RL_HI:`STL_C_RL_LO];
         end
      end
      if (wr_v && (wb_adr_i == `STL_OFF_CEIL) && wb_sel_i[0])
      begin
         d.ceil = wb_dat_i[7:0];
      end
      if (sample_stb_i)
      begin
         d.thresh = calc_th;
      end
      // hard shutdown gated by engine enable
      if (q.bo_en && q.sd_en && (q.batt < q.sd_th))
      begin
         d.sd_req = 1'b1;
      end
      unique case (q.st)
         stl_pkg::STL_IDLE:
         begin
            // priority attack regardless of limiter enable
            if (below_v && !q.stopped)
            begin
               d.st = stl_pkg::STL_ATTACK;
               d.rate_cnt = 8'h00;
               // first step on the same edge as attack entry, no strobe wait
               if ({1'b0, q.attn} + {7'h00, q.atk_st} + 9'h001 <= {1'b0, q.ceil})
               begin
                  d.attn = q.attn + {6'h00, q.atk_st} + 8'h01;
                  d.step = 1'b1;
               end
               if (q.mute_en)
               begin
                  d.mute = 1'b1;
                  d.sd_req = 1'b1;
                  d.stopped = 1'b1;
               end
            end
            else if (q.lim_en && sample_stb_i && (level_i > q.thresh) && (q.attn < q.ceil))
            begin
               d.attn = q.attn + 8'h01;
               d.step = 1'b1;
            end
         end
         stl_pkg::STL_ATTACK:
         begin
            if (!below_v)
            begin
               d.st = stl_pkg::STL_HOLD;
               d.hold_cnt = hold_samples(q.hld_tm);
            end
            else if (sample_stb_i)
            begin
               // two to the n samples per step
               d.rate_cnt = q.rate_cnt + 8'h01;
               if (q.rate_cnt == 8'((9'h001 << q.atk_rt) - 9'h001))
               begin
                  d.rate_cnt = 8'h00;
                  if ({1'b0, q.attn} + {7'h00, q.atk_st} + 9'h001 <= {1'b0, q.ceil})
                  begin
                     d.attn = q.attn + {6'h00, q.atk_st} + 8'h01;
                     d.step = 1'b1;
                  end
               end
            end
         end
         stl_pkg::STL_HOLD:
         begin
            if (below_v)
            begin
               d.st = stl_pkg::STL_IDLE;
               // new event re-enters via idle for a prompt step
            end
            else if (q.inf_hold)
            begin
               // wait for release write, mute or shutdown
               if ((wr_v && wb_adr_i == `STL_OFF_CTRL && wb_sel_i[0] && wb_dat_i[`STL_C_HCLR]) ||
                   q.mute || shutdown_i)
               begin
                  d.st = stl_pkg::STL_RELEASE;
                  d.rate_cnt = 8'h00;
               end
            end
            else if (q.hold_cnt == 16'h0000)
            begin
               d.st = stl_pkg::STL_RELEASE;
               d.rate_cnt = 8'h00;
            end
            else if (sample_stb_i)
            begin
               d.hold_cnt = q.hold_cnt - 16'h0001;
            end
         end
         stl_pkg::STL_RELEASE:
         begin
            if (below_v)
            begin
               d.st = stl_pkg::STL_IDLE;
               // new event re-enters via idle for a prompt step
            end
            else if (q.attn == 8'h00)
            begin
               d.st = stl_pkg::STL_IDLE;
            end
            else if (sample_stb_i)
            begin
               d.rate_cnt = q.rate_cnt + 8'h01;
               if (q.rate_cnt == 8'((9'h001 << q.rls_rt) - 9'h001))
               begin
                  d.rate_cnt = 8'h00;
                  d.attn = q.attn - 8'h01;
                  d.step = 1'b1;
               end
            end
         end
      endcase
      // stay stopped until shutdown state seen, shutdown wins
      if (shutdown_i)
      begin
         d.sd_req = 1'b0;
         d.mute = 1'b0;
         d.stopped = 1'b0;
      end
      // limiter frozen outside idle, so no separate release path competes
      unique case (wb_adr_i)
         `STL_OFF_UPPER: d.rdata = q.upper;
         `STL_OFF_FLOOR: d.rdata = q.floor_th;
         `STL_OFF_INFL: d.rdata = q.infl;
         `STL_OFF_SLOPE: d.rdata = q.slope;
         `STL_OFF_BO_TH: d.rdata = q.bo_th;
         `STL_OFF_SD_TH: d.rdata = q.sd_th;
         `STL_OFF_CTRL: d.rdata = {9'h000, q.rls_rt, 1'b0, q.hld_tm, 2'h0, q.atk_st, 1'b0, q.atk_rt,
                                   2'h0, q.sd_en, 1'b0, q.inf_hold, q.mute_en, q.bo_en, q.lim_en};
         `STL_OFF_STAT: d.rdata = {24'h000000, q.stopped, q.sd_req, q.mute, below_v, q.st};
         `STL_OFF_LIMTH: d.rdata = q.thresh;
         `STL_OFF_ATTN: d.rdata = {24'h000000, q.attn};
         `STL_OFF_CEIL: d.rdata = {24'h000000, q.ceil};
         default: d.rdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         q <= '0;
         q.upper <= `STL_RST_UPPER;
         q.floor_th <= `STL_RST_FLOOR;
         q.infl <= `STL_RST_INFL;
         q.slope <= `STL_RST_SLOPE;
         q.bo_th <= `STL_RST_BO_TH;
         q.sd_th <= `STL_RST_SD_TH;
         q.thresh <= `STL_RST_UPPER;
         q.batt <= 32'hFFFFFFFF;
         q.bo_en <= 1'b1;
         q.atk_rt <= `STL_RST_ATK_RT;
         q.atk_st <= `STL_RST_ATK_ST;
         q.hld_tm <= `STL_RST_HLD_TM;
         q.ceil <= `STL_RST_CEIL;
         q.st <= stl_pkg::STL_IDLE;
      end
      else
      begin
         q <= d;
      end
   end

   assign wb_dat_o = q.rdata;
   assign wb_ack_o = q.ack;
   assign limit_thresh_o = q.thresh;
   assign attn_o = q.attn;
   assign gain_step_o = q.step;
   assign mute_o = q.mute;
   assign shutdown_req_o = q.sd_req;
   assign brownout_o = q.st[1];
endmodule

// ===== verification/stl_batt_model.sv
// battery monitor and sample strobe model for the limiter bench
// assumes one clock; volts_i is the supply level the bench wants
module stl_batt_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [31:0] volts_i,
   output logic sample_stb_o,
   output logic [31:0] battery_o,
   output logic battery_vld_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] cnt_q;
   // conversion every eight cycles, inverted value between pulses
   always_ff @(posedge clk_i)
   begin
      cnt_q <= rst_i ? 3'h0 : cnt_q + 3'h1;
      sample_stb_o <= !rst_i && cnt_q == 3'h7;
      battery_vld_o <= !rst_i && cnt_q == 3'h3;
      battery_o <= (!rst_i && cnt_q == 3'h3) ? volts_i : ~volts_i;
   end
endmodule

// ===== verification/stl_limiter_monitor.sv
// port assertions for the supply tracking limiter
// assumes one clock, sync active-high reset, ceiling in lane 0 at 0x28
module stl_limiter_monitor (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [5:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic sample_stb_i,
   input wire logic [31:0] battery_i,
   input wire logic battery_vld_i,
   input wire logic [31:0] level_i,
   input wire logic shutdown_i,
   input wire logic [31:0] limit_thresh_o,
   input wire logic [7:0] attn_o,
   input wire logic gain_step_o,
   input wire logic mute_o,
   input wire logic shutdown_req_o,
   input wire logic brownout_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] ceil_q;
   // mirror of the attenuation ceiling
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ceil_q <= 8'h12;
      else if (wb_ack_o && wb_we_i && wb_adr_i == 6'h28 && wb_sel_i[0])
         ceil_q <= wb_dat_i[7:0];
   end
   default clocking mon_cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acknowledged");
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge longer than one cycle");
   chk_clear_reads_zero: assert property (
      wb_ack_o && !wb_we_i && wb_adr_i == 6'h18 |-> !wb_dat_o[4])
      else $error("hold release bit read high");
   chk_attn_ceiling: assert property (attn_o <= ceil_q)
      else $error("attenuation above ceiling");
   chk_step_moves: assert property (gain_step_o |-> attn_o != $past(attn_o))
      else $error("step pulse without attenuation change");
   chk_first_step: assert property (
      $rose(brownout_o) && $past(attn_o) + 8'h04 <= ceil_q |-> gain_step_o)
      else $error("no step at brown-out start");
   chk_attack_no_release: assert property (brownout_o |-> attn_o >= $past(attn_o))
      else $error("attenuation fell during brown-out");
   chk_mute_kept: assert property (mute_o && !shutdown_i |=> mute_o)
      else $error("mute left without shutdown");
   chk_stop_kept: assert property (shutdown_req_o && !shutdown_i |=> shutdown_req_o)
      else $error("shutdown request dropped early");
   chk_stop_clears: assert property (shutdown_i |=> !mute_o && !shutdown_req_o)
      else $error("shutdown state did not clear mute");
   chk_thresh_steady: assert property (!sample_stb_i |=> $stable(limit_thresh_o))
      else $error("threshold moved between samples");
   cover property ($rose(brownout_o));
   cover property ($rose(mute_o));
   cover property ($rose(shutdown_req_o));
endmodule

bind stl_limiter_top stl_limiter_monitor u_mon (.*);

// ===== verification/testbench.sv
// self-checking bench for the supply tracking limiter over wishbone
// assumes stl_batt_model supplies sample strobes and conversions
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [5:0] wb_adr_i = 6'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] level_i = 32'h0;
   logic shutdown_i = 1'b0;
   logic [31:0] volts = 32'h40000000;
   logic [31:0] wb_dat_o, limit_thresh_o, battery_i, rdat;
   logic [7:0] attn_o;
   logic wb_ack_o, sample_stb_i, battery_vld_i, gain_step_o, mute_o, shutdown_req_o, brownout_o, zero;
   int error_cnt = 0;
   int samples_checked = 0;
   int cnt;
   logic [31:0] rst_tab [6] = '{32'h48000000, 32'h20000000, 32'h34CCCCCD, 32'h08000000,
      32'h2E666666, 32'h2B333333};
   logic [31:0] sl [5] = '{32'h08000000, 32'h08000000, 32'h10000000, 32'h08000000, 32'h10000000};
   logic [31:0] bt [5] = '{32'h38000000, 32'h28000000, 32'h28000000, 32'h10000000, 32'h10000000};
   stl_batt_model u_batt (.clk_i(clk_i), .rst_i(rst_i), .volts_i(volts), .sample_stb_o(sample_stb_i),
      .battery_o(battery_i), .battery_vld_o(battery_vld_i));
   stl_limiter_top u_dut (.*);
   always_comb zero = (attn_o === 8'h00);
   initial
   begin
      forever #2.5 clk_i = ~clk_i;
   end
   task automatic give_verdict;
      if (error_cnt == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [3:0] s);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      do
         @(posedge clk_i);
      while (wb_ack_o !== 1'b1);
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0, 4'hF);
      check(rdat, exp);
   endtask
   task automatic samples(input int k);
      repeat (k) @(posedge clk_i iff sample_stb_i);
   endtask
   task automatic wait_hi(ref logic s, input int lim);
      cnt = 0;
      while (s !== 1'b1 && cnt < lim)
      begin
         @(posedge clk_i);
         cnt++;
      end
   endtask
   task automatic to_step(output int ns);
      ns = 0;
      do
      begin
         @(posedge clk_i);
         ns += int'(sample_stb_i);
      end
      while (gain_step_o !== 1'b1 && ns < 300);
   endtask
   function automatic logic [31:0] exp_thr(input logic [31:0] s, input logic [31:0] b);
      logic [63:0] drop;
      drop = b >= 32'h30000000 ? 64'h0 : (64'(s) * 64'(32'h30000000 - b)) >> 27;
      return drop < 64'h28000000 ? 32'(64'h40000000 - drop) : 32'h18000000;
   endfunction
   initial
   begin
      repeat (100000) @(posedge clk_i);
      error_cnt++;
      give_verdict;
   end
   initial
   begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (int i = 0; i < 6; i++)
         rd_chk(6'(4 * i), rst_tab[i]);
      wb(1'b0, 6'h18, 32'h0, 4'hF);
      check(rdat & 32'hFF8FFFFF, 32'h00061002);
      wb(1'b1, 6'h3C, 32'hFFFFFFFF, 4'hF);
      rd_chk(6'h3C, 32'h0);
      wb(1'b1, 6'h00, 32'h40000000, 4'h3);
      rd_chk(6'h00, 32'h48000000);
      wb(1'b1, 6'h00, 32'h40000000, 4'hC);
      rd_chk(6'h00, 32'h40000000);
      wb(1'b1, 6'h18, 32'h00061000, 4'hF);
      wb(1'b1, 6'h04, 32'h18000000, 4'hF);
      wb(1'b1, 6'h08, 32'h30000000, 4'hF);
      for (int i = 0; i < 5; i++)
      begin
         wb(1'b1, 6'h0C, sl[i], 4'hF);
         volts <= bt[i];
         samples(3);
         check(limit_thresh_o, exp_thr(sl[i], bt[i]));
      end
      volts <= 32'h40000000;
      samples(2);
      for (int n = 0; n < 8; n++)
      begin
         wb(1'b1, 6'h18, 32'(2 + (n << 8) + ((n % 4) << 12)), 4'hF);
         volts <= 32'h20000000;
         wait_hi(gain_step_o, 2000);
         check(32'(cnt < 2000), 32'h1);
         check(32'(brownout_o), 32'h1);
         check(32'(attn_o), 32'(n % 4 + 1));
         to_step(cnt);
         check(32'(cnt), 32'(1 << n));
         volts <= 32'h40000000;
         wait_hi(zero, 5000);
      end
      wb(1'b1, 6'h18, 32'h00203002, 4'hF);
      volts <= 32'h20000000;
      samples(12);
      check(32'(attn_o), 32'h10);
      volts <= 32'h40000000;
      to_step(cnt);
      to_step(cnt);
      check(32'(cnt), 32'h4);
      wait_hi(zero, 5000);
      wb(1'b1, 6'h18, 32'h0000300A, 4'hF);
      volts <= 32'h20000000;
      samples(8);
      volts <= 32'h40000000;
      samples(40);
      check(32'(attn_o), 32'h10);
      wb(1'b1, 6'h18, 32'h0000301A, 4'hF);
      rd_chk(6'h18, 32'h0000300A);
      samples(4);
      check(32'(attn_o < 8'h10), 32'h1);
      wait_hi(zero, 5000);
      wb(1'b1, 6'h18, 32'h00003001, 4'hF);
      level_i <= 32'h7FFFFFFF;
      samples(3);
      check(32'(attn_o), 32'h2);
      level_i <= 32'h00000000;
      wb(1'b1, 6'h18, 32'h00003006, 4'hF);
      volts <= 32'h20000000;
      wait_hi(mute_o, 500);
      samples(4);
      check({30'h0, mute_o, shutdown_req_o}, 32'h3);
      volts <= 32'h40000000;
      samples(20);
      check(32'(mute_o), 32'h1);
      shutdown_i <= 1'b1;
      samples(1);
      shutdown_i <= 1'b0;
      samples(1);
      check({30'h0, mute_o, shutdown_req_o}, 32'h0);
      wb(1'b1, 6'h18, 32'h00003020, 4'hF);
      volts <= 32'h20000000;
      samples(10);
      check(32'(shutdown_req_o), 32'h0);
      wb(1'b1, 6'h18, 32'h00003022, 4'hF);
      wait_hi(shutdown_req_o, 500);
      check(32'(shutdown_req_o), 32'h1);
      give_verdict;
   end
endmodule
